// ===== common/psta_pkg.sv
// shared constants for the program space table access block
package psta_pkg;
    // ========================================
    // table instruction codes
    localparam logic [1:0] TBL_READ_LOW = 2'h0;
    localparam logic [1:0] TBL_READ_HIGH = 2'h1;
    localparam logic [1:0] TBL_WRITE_LOW = 2'h2;
    localparam logic [1:0] TBL_WRITE_HIGH = 2'h3;
    // ========================================
    // address geometry
    localparam int CFG_SPACE_BIT = 7;
    localparam logic [7:0] EE_PAGE = 8'h7f;
    localparam int VIS_ENABLE_BIT = 2;
    localparam int ROW_WORDS = 32;
    localparam logic [23:0] ROW_SPAN = 24'h000040;
    // ========================================
    // flash operation codes
    localparam logic [3:0] OP_ERASE_ROWS = 4'h6;
    localparam logic [1:0] OP_ERASE_BAD = 2'h3;
    localparam logic [3:0] OP_WRITE_ROW = 4'h1;
    // ========================================
    // timing
    localparam int CLOCK_MHZ = 25;
    localparam int WRITE_TIME_US = 2000;
    localparam int ERASE_TIME_US = 2000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLOCK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;
    // ========================================
    // reset values
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
endpackage

// ===== design/psta_latch_mem.sv
// row holding latches with byte-lane writes and registered read
`timescale 1ns/100ps
module psta_latch_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock and enable
    input wire logic i_clock,
    input wire logic i_clk_en,
    // write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH/8-1:0] i_be,
    input wire logic [WIDTH-1:0] i_wdata,
    // read port
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ========================================
    // byte lanes, a later write replaces only its own lanes
    always_ff @(posedge i_clock) begin
        if (i_clk_en && i_we) begin
            for (int b = 0; b < WIDTH / 8; b++) begin
                if (i_be[b]) begin
                    mem[i_waddr][b*8 +: 8] <= i_wdata[b*8 +: 8];
                end
            end
        end
    end

    // registered read
    always_ff @(posedge i_clock) begin
        if (i_clk_en) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// ===== design/psta_top.sv
// table read/write engine, visibility window and row programming
`timescale 1ns/100ps
// Functional notes
// - word read low returns program bits 15:0
// - byte read low picks upper/lower low byte
// - word read high: bits 23:16, zero upper
// - byte read high: phantom byte reads zero
// - two address units per program word
// - address is table page above EA
// - page bit 7 selects configuration space
// - configuration space refuses table writes
// - low table ops reach data EEPROM words
// - window needs EA bit 15 and enable
// - window address: visibility page plus EA[14:0]
// - window returns low 16 program bits
// - window suspended during table operations
// - outside repeat: move +1, others +2
// - repeat loop: +2 only edge iterations
// - 32-word rows; erase 1/2/4, write row
// - blocks aligned to their own size
// - non-EEPROM table writes only load holding latches
// - any number of latch loads programs
// - latches load any order, last wins
// - latch write takes two cycles
// - operation field low bits set size
// - erase codes 011000/011001/011010, others nothing
// - write bit starts timed op, self-clears
module psta_top #(
    parameter int WRITE_CYC = psta_pkg::WRITE_CYCLES,
    parameter int ERASE_CYC = psta_pkg::ERASE_CYCLES
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // table instruction request
    input wire logic i_tbl_valid,
    input wire logic [1:0] i_tbl_op,
    input wire logic i_tbl_byte,
    input wire logic [15:0] i_tbl_ea,
    input wire logic [15:0] i_tbl_wdata,
    input wire logic [7:0] i_table_page_register,
    // data space access and repeat state
    input wire logic i_ds_valid,
    input wire logic [15:0] i_ds_ea,
    input wire logic i_ds_mov,
    input wire logic i_rpt_active,
    input wire logic i_rpt_first,
    input wire logic i_rpt_last,
    input wire logic i_rpt_irq_exit,
    input wire logic i_rpt_reentry,
    input wire logic [7:0] i_visibility_page_register,
    input wire logic [15:0] i_core_control_register,
    // flash control bits
    input wire logic i_fc_wr_set,
    input wire logic i_fc_wr_enable,
    input wire logic i_fc_erase,
    input wire logic [5:0] i_flash_operation_field,
    input wire logic i_fc_err_clr,
    output logic o_fc_wr,
    output logic o_fc_err,
    // program memory read port
    output logic o_pm_rd,
    output logic o_pm_ee,
    output logic [23:0] o_pm_addr,
    input wire logic [23:0] i_pm_rdata,
    // table results
    output logic o_tbl_done,
    output logic o_tbl_refused,
    output logic [15:0] o_tbl_rdata,
    // window results
    output logic o_ds_hit,
    output logic [15:0] o_ds_rdata,
    output logic [1:0] o_ds_extra,
    // data EEPROM word write
    output logic o_ee_we,
    output logic [15:0] o_ee_addr,
    output logic [15:0] o_ee_wdata,
    // flash array
    output logic o_arr_we,
    output logic [23:0] o_arr_addr,
    output logic [23:0] o_arr_wdata,
    output logic o_arr_erase,
    output logic [2:0] o_arr_erase_rows
);
    typedef enum logic [1:0] {
        FL_IDLE = 2'h0,
        FL_STREAM = 2'h1,
        FL_WAIT = 2'h2
    } psta_fl_state_t;

    // ========================================
    // table and window pipeline state
    logic o_pm_rd_d, o_pm_ee_d, o_tbl_done_d, o_tbl_refused_d;
    logic [23:0] o_pm_addr_d;
    logic [15:0] o_tbl_rdata_d, o_ds_rdata_d, o_ee_addr_d, o_ee_wdata_d;
    logic o_ds_hit_d, o_ee_we_d;
    logic [1:0] o_ds_extra_d;
    logic s1_tbl_q, s1_tbl_d, s1_rd_q, s1_rd_d, s1_ref_q, s1_ref_d;
    logic s1_high_q, s1_high_d, s1_byte_q, s1_byte_d, s1_bsel_q, s1_bsel_d;
    logic s1_ds_q, s1_ds_d;
    logic [1:0] s1_extra_q, s1_extra_d;
    logic [23:0] wa_q, wa_d;
    logic tbl_take, ds_take, is_write, is_high, in_cfg, in_ee, refuse;
    logic lat_we;
    logic [2:0] lat_be;
    logic [23:0] lat_wdata;
    // flash sequencer state
    psta_fl_state_t st_q, st_d;
    logic o_fc_wr_d, o_fc_err_d, o_arr_we_d, o_arr_erase_d;
    logic [23:0] o_arr_addr_d, base_q, base_d;
    logic [2:0] o_arr_erase_rows_d;
    logic [4:0] idx_q, idx_d, idxp_q, idxp_d;
    logic pend_q, pend_d;
    logic [31:0] cnt_q, cnt_d;
    logic [23:0] lat_rdata, blk_mask;
    logic fl_idle;

    assign fl_idle = (st_q == FL_IDLE) && !o_fc_wr;

    // ========================================
    // table engine and window: request decode and result shaping
    always_comb begin
        is_write = i_tbl_op[1];
        is_high = i_tbl_op[0];
        in_cfg = i_table_page_register[psta_pkg::CFG_SPACE_BIT];
        in_ee = i_table_page_register == psta_pkg::EE_PAGE;
        refuse = (is_write && in_cfg) || (is_high && in_ee);
        tbl_take = i_tbl_valid && fl_idle;
        // a table op in flight or arriving holds the window off
        ds_take = i_ds_valid && i_ds_ea[15] && fl_idle && !i_tbl_valid
            && !s1_tbl_q
            && i_core_control_register[psta_pkg::VIS_ENABLE_BIT];
        o_pm_rd_d = (tbl_take && !is_write && !refuse) || ds_take;
        o_pm_ee_d = tbl_take && in_ee;
        o_pm_addr_d = o_pm_addr;
        if (tbl_take) begin
            o_pm_addr_d = {i_table_page_register, i_tbl_ea};
        end else if (ds_take) begin
            o_pm_addr_d = {1'b0, i_visibility_page_register,
                i_ds_ea[14:0]};
        end
        // latch loads: array untouched until a sequence runs
        lat_we = tbl_take && is_write && !refuse && !in_ee;
        lat_be = 3'h0;
        lat_wdata = {i_tbl_wdata[7:0], i_tbl_wdata};
        if (lat_we) begin
            if (!is_high && !i_tbl_byte) begin
                lat_be = 3'h3;
            end else if (!is_high) begin
                lat_be = i_tbl_ea[0] ? 3'h2 : 3'h1;
                lat_wdata = {3{i_tbl_wdata[7:0]}};
            end else if (!(i_tbl_byte && i_tbl_ea[0])) begin
                lat_be = 3'h4; // phantom byte write is dropped
            end
        end
        wa_d = lat_we ? {i_table_page_register, i_tbl_ea} : wa_q;
        o_ee_we_d = tbl_take && is_write && in_ee && !is_high;
        o_ee_addr_d = o_ee_we_d ? i_tbl_ea : o_ee_addr;
        o_ee_wdata_d = o_ee_we_d ? i_tbl_wdata : o_ee_wdata;
        // stage one bookkeeping
        s1_tbl_d = tbl_take;
        s1_rd_d = tbl_take && !is_write && !refuse;
        s1_ref_d = tbl_take && refuse;
        s1_high_d = is_high;
        s1_byte_d = i_tbl_byte;
        s1_bsel_d = i_tbl_ea[0];
        s1_ds_d = ds_take;
        if (!i_rpt_active) begin
            s1_extra_d = i_ds_mov ? 2'h1 : 2'h2;
        end else if (i_rpt_first || i_rpt_last || i_rpt_irq_exit
            || i_rpt_reentry) begin
            s1_extra_d = 2'h2;
        end else begin
            s1_extra_d = 2'h0;
        end
        // stage two: answer, write done after two cycles
        o_tbl_done_d = s1_tbl_q;
        o_tbl_refused_d = s1_ref_q;
        o_tbl_rdata_d = 16'h0000;
        if (s1_rd_q) begin
            if (!s1_high_q && !s1_byte_q) begin
                o_tbl_rdata_d = i_pm_rdata[15:0];
            end else if (!s1_high_q) begin
                o_tbl_rdata_d = {8'h00, s1_bsel_q ? i_pm_rdata[15:8]
                    : i_pm_rdata[7:0]};
            end else if (!(s1_byte_q && s1_bsel_q)) begin
                o_tbl_rdata_d = {8'h00, i_pm_rdata[23:16]};
            end
        end
        o_ds_hit_d = s1_ds_q;
        o_ds_rdata_d = s1_ds_q ? i_pm_rdata[15:0] : o_ds_rdata;
        o_ds_extra_d = s1_ds_q ? s1_extra_q : 2'h0;
    end

    // table and window registers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pm_rd <= 1'b0;
            o_pm_ee <= 1'b0;
            o_pm_addr <= psta_pkg::ADDR_RESET;
            wa_q <= psta_pkg::ADDR_RESET;
            o_ee_we <= 1'b0;
            o_ee_addr <= psta_pkg::DATA_RESET;
            o_ee_wdata <= psta_pkg::DATA_RESET;
            {s1_tbl_q, s1_rd_q, s1_ref_q, s1_high_q} <= 4'h0;
            {s1_byte_q, s1_bsel_q, s1_ds_q} <= 3'h0;
            s1_extra_q <= 2'h0;
            o_tbl_done <= 1'b0;
            o_tbl_refused <= 1'b0;
            o_tbl_rdata <= psta_pkg::DATA_RESET;
            o_ds_hit <= 1'b0;
            o_ds_rdata <= psta_pkg::DATA_RESET;
            o_ds_extra <= 2'h0;
        end else if (i_clk_en) begin
            o_pm_rd <= o_pm_rd_d;
            o_pm_ee <= o_pm_ee_d;
            o_pm_addr <= o_pm_addr_d;
            wa_q <= wa_d;
            o_ee_we <= o_ee_we_d;
            o_ee_addr <= o_ee_addr_d;
            o_ee_wdata <= o_ee_wdata_d;
            {s1_tbl_q, s1_rd_q, s1_ref_q, s1_high_q} <=
                {s1_tbl_d, s1_rd_d, s1_ref_d, s1_high_d};
            {s1_byte_q, s1_bsel_q, s1_ds_q} <= {s1_byte_d, s1_bsel_d, s1_ds_d};
            s1_extra_q <= s1_extra_d;
            o_tbl_done <= o_tbl_done_d;
            o_tbl_refused <= o_tbl_refused_d;
            o_tbl_rdata <= o_tbl_rdata_d;
            o_ds_hit <= o_ds_hit_d;
            o_ds_rdata <= o_ds_rdata_d;
            o_ds_extra <= o_ds_extra_d;
        end
    end

    // ========================================
    // holding latches for one row
    psta_latch_mem #(
        .WIDTH(24),
        .DEPTH(psta_pkg::ROW_WORDS),
        .AW(5)
    ) u_latch (
        .i_clock(i_clock),
        .i_clk_en(i_clk_en),
        .i_we(lat_we),
        .i_waddr(i_tbl_ea[5:1]),
        .i_be(lat_be),
        .i_wdata(lat_wdata),
        .i_raddr(idx_q),
        .o_rdata(lat_rdata)
    );

    // ========================================
    // flash sequencer: erase blocks and row write
    always_comb begin
        st_d = st_q;
        o_fc_wr_d = o_fc_wr;
        o_fc_err_d = o_fc_err && !i_fc_err_clr;
        o_arr_erase_d = 1'b0;
        o_arr_erase_rows_d = o_arr_erase_rows;
        base_d = base_q;
        idx_d = idx_q;
        idxp_d = idx_q;
        pend_d = 1'b0;
        cnt_d = cnt_q;
        blk_mask = (psta_pkg::ROW_SPAN
            << i_flash_operation_field[1:0]) - 24'h000001;
        unique case (st_q)
            FL_IDLE: begin
                if (i_fc_wr_set && !o_fc_wr && !i_fc_wr_enable) begin
                    o_fc_err_d = 1'b1; // set wins over clear
                end else if (i_fc_wr_set && !o_fc_wr) begin
                    if (i_fc_erase
                        && i_flash_operation_field[5:2] == psta_pkg::OP_ERASE_ROWS
                        && i_flash_operation_field[1:0] != psta_pkg::OP_ERASE_BAD)
                    begin
                        o_fc_wr_d = 1'b1;
                        o_arr_erase_d = 1'b1;
                        o_arr_erase_rows_d = 3'h1 << i_flash_operation_field[1:0];
                        base_d = wa_q & ~blk_mask;
                        cnt_d = 32'(ERASE_CYC);
                        st_d = FL_WAIT;
                    end else if (!i_fc_erase
                        && i_flash_operation_field[5:2] == psta_pkg::OP_WRITE_ROW)
                    begin
                        o_fc_wr_d = 1'b1;
                        base_d = wa_q & ~(psta_pkg::ROW_SPAN - 24'h000001);
                        idx_d = 5'h00;
                        st_d = FL_STREAM;
                    end
                end
            end
            FL_STREAM: begin
                pend_d = 1'b1;
                idx_d = idx_q + 5'h01;
                if (idx_q == 5'(psta_pkg::ROW_WORDS - 1)) begin
                    cnt_d = 32'(WRITE_CYC);
                    st_d = FL_WAIT;
                end
            end
            FL_WAIT: begin
                cnt_d = cnt_q - 32'h00000001;
                if (cnt_q <= 32'h00000001) begin
                    o_fc_wr_d = 1'b0;
                    st_d = FL_IDLE;
                end
            end
            default: st_d = FL_IDLE;
        endcase
        o_arr_we_d = pend_q;
        o_arr_addr_d = o_arr_erase_d ? base_d : o_arr_addr;
        if (pend_q) begin
            o_arr_addr_d = base_q + {18'h00000, idxp_q, 1'b0};
        end
    end

    // flash sequencer registers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= FL_IDLE;
            o_fc_wr <= 1'b0;
            o_fc_err <= 1'b0;
            o_arr_erase <= 1'b0;
            o_arr_erase_rows <= 3'h0;
            o_arr_we <= 1'b0;
            o_arr_addr <= psta_pkg::ADDR_RESET;
            o_arr_wdata <= psta_pkg::ADDR_RESET;
            base_q <= psta_pkg::ADDR_RESET;
            idx_q <= 5'h00;
            idxp_q <= 5'h00;
            pend_q <= 1'b0;
            cnt_q <= 32'h00000000;
        end else if (i_clk_en) begin
            st_q <= st_d;
            o_fc_wr <= o_fc_wr_d;
            o_fc_err <= o_fc_err_d;
            o_arr_erase <= o_arr_erase_d;
            o_arr_erase_rows <= o_arr_erase_rows_d;
            o_arr_we <= o_arr_we_d;
            o_arr_addr <= o_arr_addr_d;
            o_arr_wdata <= pend_q ? lat_rdata : o_arr_wdata;
            base_q <= base_d;
            idx_q <= idx_d;
            idxp_q <= idxp_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n || !i_clk_en);

    sequence s_rdl_word;
        tbl_take && i_tbl_op == psta_pkg::TBL_READ_LOW && !i_tbl_byte
            && !refuse;
    endsequence
    sequence s_rdh;
        tbl_take && i_tbl_op == psta_pkg::TBL_READ_HIGH && !refuse;
    endsequence

    AST_RDL_WORD: assert property (s_rdl_word |-> ##2 (o_tbl_done
        && o_tbl_rdata == $past(i_pm_rdata[15:0])))
        else $error("word read low data wrong");
    AST_RDH_ZERO_TOP: assert property (s_rdh |-> ##2
        o_tbl_rdata[15:8] == 8'h00) else $error("phantom byte not zero");
    AST_RDH_PHANTOM: assert property ((s_rdh ##0 (i_tbl_byte
        && i_tbl_ea[0])) |-> ##2 o_tbl_rdata == 16'h0000)
        else $error("phantom byte select not zero");
    AST_TBL_ADDR: assert property ((tbl_take && !is_write) |=>
        o_pm_addr == {$past(i_table_page_register), $past(i_tbl_ea)})
        else $error("table address wrong");
    AST_CFG_NO_WRITE: assert property ((tbl_take && is_write && in_cfg)
        |-> !lat_we ##2 o_tbl_refused) else $error("config write taken");
    AST_WIN_ADDR: assert property (ds_take |=> o_pm_rd
        && o_pm_addr[23] == 1'b0
        && o_pm_addr[14:0] == $past(i_ds_ea[14:0]))
        else $error("window address wrong");
    AST_WIN_SUSPEND: assert property ((i_tbl_valid && fl_idle)
        |-> ##2 !o_ds_hit ##1 !o_ds_hit)
        else $error("window during table op");
    AST_WIN_MOV: assert property ((ds_take && !i_rpt_active && i_ds_mov)
        |-> ##2 (o_ds_hit && o_ds_extra == 2'h1))
        else $error("move window penalty wrong");
    AST_ERASE_ALIGN: assert property (o_arr_erase |->
        o_arr_addr[5:0] == 6'h00 && o_fc_wr)
        else $error("erase block misaligned");
    AST_ROW_STREAM: assert property ((st_q == FL_STREAM
        && idx_q == 5'h00) |=> ##1 o_arr_we[*8])
        else $error("row stream broken");
endmodule

// ===== tb/psta_pm_model.sv
// program memory model answering the block's read port
`timescale 1ns/100ps
module psta_pm_model (
    // clock
    input wire logic i_clock,
    // read request from the block
    input wire logic i_rd,
    input wire logic [23:0] i_addr,
    // read data back to the block
    output logic [23:0] o_rdata
);
    // ========================================
    // filler that changes every cycle while no read is pending
    logic [23:0] junk_q = 24'h5a5a5a;
    always_ff @(posedge i_clock) begin
        junk_q <= junk_q + 24'h1c3d5b;
    end
    // word contents are a fixed function of the address
    assign o_rdata = i_rd ? {i_addr[7:0] ^ 8'h3c,
        i_addr[15:0] ^ {i_addr[23:16], 8'h61}} : junk_q;
endmodule

// ===== tb/psta_test.sv
// self-checking testbench for the program space table access block
`timescale 1ns/100ps
module psta_test;
    // ========================================
    // stimulus and observation signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tv = 1'b0, tby = 1'b0, dv = 1'b0, dmov = 1'b0;
    logic wset = 1'b0, wen = 1'b0, ers = 1'b0, eclr = 1'b0;
    logic [1:0] top = 2'h0;
    logic [15:0] tea = 16'h0000, twd = 16'h0000, dea = 16'h0000;
    logic [15:0] core = 16'h0000;
    logic [7:0] tpg = 8'h00, vpg = 8'h00;
    logic [4:0] rpt = 5'h00;
    logic [5:0] fop = 6'h00;
    logic fc_wr, fc_err, pm_rd, pm_ee, done, refd, ds_hit, ee_we;
    logic arr_we, arr_er;
    logic [23:0] pm_addr, pm_rdata, arr_addr, arr_wd, pa, w, er_addr;
    logic [15:0] rdata, ds_rd, ee_addr, ee_wd, rd, eea, eed, ea;
    logic [1:0] ds_ex;
    logic [2:0] arr_rows, er_rows;
    logic pee, eew, rf, fst, ferr, prd;
    int err_total = 0, samples_checked = 0, we_n = 0, er_n = 0, n;
    // ========================================
    // block under test and its program memory
    psta_top #(.WRITE_CYC(20), .ERASE_CYC(20)) psta_top_inst (
        .i_clock(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
        .i_tbl_valid(tv), .i_tbl_op(top), .i_tbl_byte(tby),
        .i_tbl_ea(tea), .i_tbl_wdata(twd), .i_table_page_register(tpg),
        .i_ds_valid(dv), .i_ds_ea(dea), .i_ds_mov(dmov),
        .i_rpt_active(rpt[4]), .i_rpt_first(rpt[3]), .i_rpt_last(rpt[2]),
        .i_rpt_irq_exit(rpt[1]), .i_rpt_reentry(rpt[0]),
        .i_visibility_page_register(vpg), .i_core_control_register(core),
        .i_fc_wr_set(wset), .i_fc_wr_enable(wen), .i_fc_erase(ers),
        .i_flash_operation_field(fop), .i_fc_err_clr(eclr),
        .o_fc_wr(fc_wr), .o_fc_err(fc_err), .o_pm_rd(pm_rd),
        .o_pm_ee(pm_ee), .o_pm_addr(pm_addr), .i_pm_rdata(pm_rdata),
        .o_tbl_done(done), .o_tbl_refused(refd), .o_tbl_rdata(rdata),
        .o_ds_hit(ds_hit), .o_ds_rdata(ds_rd), .o_ds_extra(ds_ex),
        .o_ee_we(ee_we), .o_ee_addr(ee_addr), .o_ee_wdata(ee_wd),
        .o_arr_we(arr_we), .o_arr_addr(arr_addr), .o_arr_wdata(arr_wd),
        .o_arr_erase(arr_er), .o_arr_erase_rows(arr_rows));
    psta_pm_model psta_pm_model_inst (.i_clock(clk), .i_rd(pm_rd),
        .i_addr(pm_addr), .o_rdata(pm_rdata));
    // ========================================
    // helpers
    function automatic logic [23:0] pmw(input logic [23:0] a);
        return {a[7:0] ^ 8'h3c, a[15:0] ^ {a[23:16], 8'h61}};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one table instruction, entered and left at a falling edge
    task automatic tbl(input logic [1:0] op, input logic by,
        input logic [7:0] pg, input logic [15:0] a, input logic [15:0] wd);
        tv = 1'b1;
        top = op;
        tby = by;
        tpg = pg;
        tea = a;
        twd = wd;
        @(negedge clk);
        tv = 1'b0;
        pa = pm_addr;
        pee = pm_ee;
        eew = ee_we;
        eea = ee_addr;
        eed = ee_wd;
        @(negedge clk);
        chk(done, 1'b1);
        rf = refd;
        rd = rdata;
    endtask
    // one data space read, optionally beside a table request
    task automatic ds(input logic [15:0] a, input logic mov,
        input logic [4:0] rp, input logic with_tbl);
        dv = 1'b1;
        dea = a;
        dmov = mov;
        rpt = rp;
        tv = with_tbl;
        top = 2'h0;
        tpg = 8'h00;
        @(negedge clk);
        dv = 1'b0;
        tv = 1'b0;
        pa = pm_addr;
        prd = pm_rd;
        @(negedge clk);
    endtask
    // set the write-control bit and wait for the timed operation
    task automatic fl(input logic er, input logic [5:0] op, input logic en);
        ers = er;
        fop = op;
        wen = en;
        wset = 1'b1; // unlock keys are taken as already written
        @(negedge clk);
        wset = 1'b0;
        fst = fc_wr;
        ferr = fc_err;
        for (n = 0; n < 200 && fc_wr === 1'b1; n++) @(negedge clk);
        chk(fc_wr, 1'b0);
    endtask
    // ========================================
    // array write and erase monitors
    always @(negedge clk) begin
        if (arr_we === 1'b1) begin
            chk(arr_addr, 24'h40 + 24'(2 * we_n));
            chk(arr_wd, {8'ha0 ^ 8'(we_n), (we_n == 3) ? 16'hbeef :
                16'h1200 + 16'(we_n)});
            we_n++;
        end
        if (arr_er === 1'b1) begin
            er_n++;
            er_addr = arr_addr;
            er_rows = arr_rows;
        end
    end
    // ========================================
    // clock, watchdog and test sequence
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 20000);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        w = pmw(24'h123456);
        tbl(2'h0, 1'b0, 8'h12, 16'h3456, 16'h0);
        chk(pa, 24'h123456);
        chk(rd, w[15:0]);
        tbl(2'h0, 1'b1, 8'h12, 16'h3456, 16'h0);
        chk(rd[7:0], w[7:0]);
        tbl(2'h1, 1'b0, 8'h12, 16'h3456, 16'h0);
        chk(pa, 24'h123456);
        chk(rd, {8'h00, w[23:16]});
        tbl(2'h1, 1'b1, 8'h12, 16'h3456, 16'h0);
        chk(rd[7:0], w[23:16]);
        tbl(2'h1, 1'b1, 8'h12, 16'h3457, 16'h0);
        chk(rd, 16'h0000);
        w = pmw(24'h123457);
        tbl(2'h0, 1'b1, 8'h12, 16'h3457, 16'h0);
        chk(rd[7:0], w[15:8]);
        tbl(2'h2, 1'b0, 8'h80, 16'h0010, 16'h1234);
        chk(rf, 1'b1);
        tbl(2'h3, 1'b0, 8'h80, 16'h0010, 16'h1234);
        chk(rf, 1'b1);
        tbl(2'h0, 1'b0, 8'h81, 16'h0002, 16'h0);
        chk({rf, pa}, 25'h0810002);
        tbl(2'h2, 1'b0, 8'h7f, 16'h0010, 16'ha55a);
        chk({eew, eea, eed[7:0]}, 25'h100105a);
        chk(eed, 16'ha55a);
        tbl(2'h0, 1'b0, 8'h7f, 16'h0010, 16'h0);
        chk(pee, 1'b1);
        tbl(2'h1, 1'b0, 8'h7f, 16'h0010, 16'h0);
        chk(rf, 1'b1);
        core = 16'h0004;
        vpg = 8'ha5;
        for (int c = 0; c < 7; c++) begin
            ea = 16'hc246 + 16'(2 * c);
            ds(ea, c == 0, (c < 2) ? 5'h00 : 5'h10 | (5'h10 >> (c - 1)), 0);
            w = pmw({1'b0, vpg, ea[14:0]});
            chk(ds_hit, 1'b1);
            chk(prd, 1'b1);
            chk(pa, {1'b0, vpg, ea[14:0]});
            chk(ds_rd, w[15:0]);
            chk(ds_ex, (c == 0) ? 2'h1 : (c == 6) ? 2'h0 : 2'h2);
        end
        ds(16'h4246, 1'b0, 5'h00, 1'b0);
        chk(ds_hit, 1'b0);
        core = 16'hfffb;
        ds(16'hc246, 1'b0, 5'h00, 1'b0);
        chk(ds_hit, 1'b0);
        core = 16'h0004;
        ds(16'hc246, 1'b0, 5'h00, 1'b1);
        chk(ds_hit, 1'b0);
        // window request in the cycle right after a table take
        tv = 1'b1;
        @(negedge clk);
        tv = 1'b0;
        dv = 1'b1;
        @(negedge clk);
        dv = 1'b0;
        @(negedge clk);
        chk(ds_hit, 1'b0);
        @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            tbl(2'h2, 1'b0, 8'h00, 16'h0040 + 16'(2 * i), 16'h1200 + 16'(i));
            tbl(2'h3, 1'b0, 8'h00, 16'h0040 + 16'(2 * i), 16'(8'ha0 ^ i));
        end
        tbl(2'h2, 1'b0, 8'h00, 16'h0046, 16'hbeef);
        chk(we_n, 0);
        fl(1'b0, 6'h04, 1'b1);
        chk(fst, 1'b1);
        chk(we_n, 32);
        for (int k = 0; k < 3; k++) begin
            tbl(2'h2, 1'b0, 8'h01, 16'h01e6, 16'h0);
            fl(1'b1, 6'h18 + 6'(k), 1'b1);
            chk({fst, 24'(er_n)}, {1'b1, 24'(k + 1)});
            chk(er_addr, 24'h0101e6 & ~((24'h40 << k) - 24'h1));
            chk(er_rows, 3'h1 << k);
        end
        fl(1'b1, 6'h1b, 1'b1);
        chk({fst, fc_err}, 2'h0);
        fl(1'b1, 6'h04, 1'b1);
        chk({fst, 24'(er_n), 24'(we_n)}, {25'h3, 24'd32});
        fl(1'b1, 6'h18, 1'b0);
        chk({fst, ferr}, 2'h1);
        eclr = 1'b1;
        @(negedge clk);
        eclr = 1'b0;
        chk(fc_err, 1'b0);
        report_and_stop();
    end
endmodule
